//--- core/uig_defs.svh
// offsets, field positions and reset values for the irq enable gate
`ifndef UIG_DEFS_SVH
`define UIG_DEFS_SVH

`define UIG_STATUS_OFS     12'h00C
`define UIG_ENABLE_OFS     12'h010
`define UIG_OFS_W          12
`define UIG_DATA_W         32
`define UIG_MIE_BIT        31
`define UIG_OC_BIT         30
`define UIG_EVT_MASK       32'h4000_007F
`define UIG_ENABLE_RST     32'h0000_0000

`endif

//--- core/uig_pkg.sv
// types for the irq enable gate
package uig_pkg;
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [11:0] ofs;
        logic [31:0] wdata;
    } uig_req_s;
endpackage

//--- core/uig_irq_enable_gate.sv
// interrupt enable register with level interrupt request gating
`timescale 1ns/1ns
`default_nettype none
`include "uig_defs.svh"

////////////////////////////////////////////////////////////////////////////
// How it works
// [R1] enable bit n gates status bit n at the same position, for bits 0 to 6 and 30 only.
// [R2] the request is raised only while status, enable and master all hold.
// [R3] writing a one to an enable bit sets it.
// [R4] writing a zero to an enable bit leaves it unchanged.
// [R5] a read returns every enable bit with no side effect.
// [R6] the register decodes at offset 10h of the function's memory range.
// [R7] status bits are cleared only by host write-one, never by this block.
// [R8] the request is a level that drops when any gating condition fails.
module uig_irq_enable_gate
    import uig_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // register access from the function's memory range
    input  wire uig_req_s    req_i,
    output logic      [31:0] rdata_o,
    output logic             rvalid_o,
    // event status from the status register
    input  wire logic [31:0] event_irq_status_i,
    // interrupt request to the host bus
    output logic             irq_o
);

    logic [31:0] event_irq_enable_ff;
    logic [31:0] rdata_ff;
    logic        rvalid_ff;
    logic        irq_ff;
    logic        hit;
    logic [31:0] pend;
    logic        nxt_irq;

    localparam logic [31:0] evt_mask = `UIG_EVT_MASK;

    assign hit = req_i.sel && (req_i.ofs == `UIG_ENABLE_OFS); // R6

    ////////////////////////////////////////////////////////////////////////
    // enable register: write one to set
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            event_irq_enable_ff <= `UIG_ENABLE_RST;
        end else if (hit && req_i.wr) begin
            event_irq_enable_ff <= event_irq_enable_ff | req_i.wdata; // R3 R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, no side effect
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff  <= 32'h0000_0000;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= req_i.sel && !req_i.wr;
            rdata_ff  <= hit ? event_irq_enable_ff : 32'h0000_0000; // R5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt gating; status is only observed here
    // one gate per status bit, paired by bit position
    for (genvar gi = 0; gi < `UIG_DATA_W; gi++) begin : g_pair
        assign pend[gi] = event_irq_status_i[gi]
                        & event_irq_enable_ff[gi]
                        & evt_mask[gi]; // R1 R7
    end

    assign nxt_irq = (|pend) && event_irq_enable_ff[`UIG_MIE_BIT]; // R2 R8

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    assign rdata_o  = rdata_ff;
    assign rvalid_o = rvalid_ff;
    assign irq_o    = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_set_on_one;
        @(posedge ref_clk_i) disable iff (rst_i)
        (hit && req_i.wr) |=> ((event_irq_enable_ff & $past(req_i.wdata))
                              == $past(req_i.wdata));
    endproperty
    a_set_on_one: assert property (p_set_on_one) // R3
        else $error("enable bit not set by write one");

    property p_keep_on_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        1'b1 |=> ((event_irq_enable_ff & $past(event_irq_enable_ff))
                 == $past(event_irq_enable_ff));
    endproperty
    a_keep_on_zero: assert property (p_keep_on_zero) // R4
        else $error("enable bit cleared");

    property p_no_write_stable;
        @(posedge ref_clk_i) disable iff (rst_i)
        !(hit && req_i.wr) |=> $stable(event_irq_enable_ff);
    endproperty
    a_no_write_stable: assert property (p_no_write_stable) // R5
        else $error("enable changed without write");

    property p_read_value;
        @(posedge ref_clk_i) disable iff (rst_i)
        (hit && !req_i.wr) |=> (rvalid_o && rdata_o ==
                                $past(event_irq_enable_ff));
    endproperty
    a_read_value: assert property (p_read_value) // R5
        else $error("read data wrong");

    property p_irq_needs_all;
        @(posedge ref_clk_i) disable iff (rst_i)
        irq_o |-> $past(event_irq_enable_ff[`UIG_MIE_BIT]) &&
                  ($past(event_irq_status_i & event_irq_enable_ff
                         & `UIG_EVT_MASK) != 32'h0000_0000);
    endproperty
    a_irq_needs_all: assert property (p_irq_needs_all) // R2
        else $error("irq without cause");

    property p_irq_follows;
        @(posedge ref_clk_i) disable iff (rst_i)
        (event_irq_enable_ff[`UIG_MIE_BIT] &&
         |(event_irq_status_i & event_irq_enable_ff & `UIG_EVT_MASK))
        |=> irq_o;
    endproperty
    a_irq_follows: assert property (p_irq_follows) // R1
        else $error("irq missing");

    property p_irq_drops;
        @(posedge ref_clk_i) disable iff (rst_i)
        !event_irq_enable_ff[`UIG_MIE_BIT] |=> !irq_o;
    endproperty
    a_irq_drops: assert property (p_irq_drops) // R8
        else $error("irq held without master");

    property p_offset;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.sel && req_i.wr && req_i.ofs != `UIG_ENABLE_OFS)
        |=> $stable(event_irq_enable_ff);
    endproperty
    a_offset: assert property (p_offset) // R6
        else $error("write decoded at wrong offset");

    property p_write_exact;
        @(posedge ref_clk_i) disable iff (rst_i)
        (hit && req_i.wr) |=> (event_irq_enable_ff ==
            ($past(event_irq_enable_ff) | $past(req_i.wdata)));
    endproperty
    a_write_exact: assert property (p_write_exact) // R4
        else $error("enable not old value or write data");

    property p_read_no_side;
        @(posedge ref_clk_i) disable iff (rst_i)
        (hit && !req_i.wr)
        |=> $stable(event_irq_enable_ff);
    endproperty
    a_read_no_side: assert property (p_read_no_side) // R5
        else $error("read changed enable");

    property p_rvalid_only_read;
        @(posedge ref_clk_i) disable iff (rst_i)
        !(req_i.sel && !req_i.wr)
        |=> !rvalid_o;
    endproperty
    a_rvalid_only_read: assert property (p_rvalid_only_read) // R5
        else $error("read valid without read");

    property p_read_other_zero;
        @(posedge ref_clk_i) disable iff (rst_i)
        (req_i.sel && !req_i.wr && req_i.ofs != `UIG_ENABLE_OFS)
        |=> (rvalid_o && (rdata_o == 32'h0000_0000));
    endproperty
    a_read_other_zero: assert property (p_read_other_zero) // R6
        else $error("read at other offset not zero");

    property p_irq_off_no_pend;
        @(posedge ref_clk_i) disable iff (rst_i)
        !(|pend)
        |=> !irq_o;
    endproperty
    a_irq_off_no_pend: assert property (p_irq_off_no_pend) // R8
        else $error("irq held without pending event");

    property p_reserved_ignored;
        @(posedge ref_clk_i) disable iff (rst_i)
        ((event_irq_status_i & `UIG_EVT_MASK) == 32'h0000_0000)
        |=> !irq_o;
    endproperty
    a_reserved_ignored: assert property (p_reserved_ignored) // R1
        else $error("irq from unused status bit");

    property p_oc_pairs;
        @(posedge ref_clk_i) disable iff (rst_i)
        (event_irq_enable_ff[`UIG_MIE_BIT]
         && event_irq_status_i[`UIG_OC_BIT]
         && event_irq_enable_ff[`UIG_OC_BIT]) |=> irq_o;
    endproperty
    a_oc_pairs: assert property (p_oc_pairs) // R1
        else $error("ownership event did not raise irq");

    property p_irq_status_gate;
        @(posedge ref_clk_i) disable iff (rst_i)
        irq_o
        |-> $past(|(event_irq_status_i & `UIG_EVT_MASK));
    endproperty
    a_irq_status_gate: assert property (p_irq_status_gate) // R2
        else $error("irq without status bit");

    property p_irq_enable_gate;
        @(posedge ref_clk_i) disable iff (rst_i)
        irq_o
        |-> $past(|(event_irq_enable_ff & `UIG_EVT_MASK));
    endproperty
    a_irq_enable_gate: assert property (p_irq_enable_gate) // R2
        else $error("irq without enable bit");

endmodule
`default_nettype wire

//--- tb/uig_status_model.sv
// event status register model on the host side
`timescale 1ns/1ns
`default_nettype none
module uig_status_model (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // events and host write-one clears
    input  wire logic [31:0] set_i,
    input  wire logic [31:0] clr_i,
    // status
    output logic      [31:0] status_o
);
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_o <= 32'h0000_0000;
        end else begin
            status_o <= (status_o & ~clr_i) | set_i;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_usb_host_irq_enable_gate.sv
// testbench for the irq enable gate
`timescale 1ns/1ns
`default_nettype none
module tb_usb_host_irq_enable_gate;
    import uig_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    uig_req_s    req = '0;
    logic [31:0] rdata, st, rv;
    logic [31:0] set = '0, clr = '0;
    logic        rvalid, irq;
    int          err_total = 0, num_checks = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    uig_status_model i_sts (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .set_i(set), .clr_i(clr), .status_o(st));
    uig_irq_enable_gate i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .event_irq_status_i(st), .irq_o(irq));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] o,
                       input logic [31:0] d);
        @(posedge ref_clk_i) req <= '{1'b1, w, o, d};
        @(posedge ref_clk_i) req <= '0;
    endtask
    task automatic rd(input logic [11:0] o);
        int n;
        acc(1'b0, o, 32'h0000_0000);
        #1;
        for (n = 0; n < 4 && rvalid !== 1'b1; n++) @(posedge ref_clk_i) #1;
        chk({31'h0, rvalid}, 32'h0000_0001);
        if (n == 4) begin
            stop_test();
        end else begin
            rv = rdata;
        end
    endtask
    task automatic irqchk(input logic exp);
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(12'h010);
        chk(rv, 32'h0000_0000);
        acc(1'b1, 12'h010, 32'h0000_0041);
        acc(1'b1, 12'h010, 32'h0000_0000);
        acc(1'b1, 12'h00C, 32'hFFFF_FFFF);
        rd(12'h010);
        chk(rv, 32'h0000_0041);
        rd(12'h00C);
        chk(rv, 32'h0000_0000);
        $display("register test done");
        @(posedge ref_clk_i) set <= 32'h0000_0003;
        @(posedge ref_clk_i) set <= '0;
        irqchk(1'b0);
        acc(1'b1, 12'h010, 32'h8000_0000);
        irqchk(1'b1);
        rd(12'h010);
        chk(rv, 32'h8000_0041);
        @(posedge ref_clk_i) clr <= 32'h0000_0001;
        @(posedge ref_clk_i) clr <= '0;
        irqchk(1'b0);
        acc(1'b1, 12'h010, 32'h0000_0080);
        rd(12'h010);
        chk(rv, 32'h8000_00C1);
        @(posedge ref_clk_i) set <= 32'h0000_0080;
        @(posedge ref_clk_i) set <= '0;
        irqchk(1'b0);
        acc(1'b1, 12'h010, 32'h4000_0000);
        @(posedge ref_clk_i) set <= 32'h4000_0000;
        @(posedge ref_clk_i) set <= '0;
        irqchk(1'b1);
        @(posedge ref_clk_i) clr <= 32'h4000_0000;
        @(posedge ref_clk_i) clr <= '0;
        irqchk(1'b0);
        $display("gating test done");
        @(posedge ref_clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(12'h010);
        chk(rv, 32'h0000_0000);
        irqchk(1'b0);
        $display("reset test done");
        stop_test();
    end
endmodule
`default_nettype wire
